// ==== cpb_pkg.sv ====
// Constants and types for the complementary PWM buffer controller
// Function
// - Period fixed while complementary PWM runs
// - Counter zero turns m-1,m,m+1,m,m-1
// - Period match flag set on m to m+1
// - Mode 11 transfers buffers at m to m+1
// - No flag change or transfer after top turn
// - Counter one turns 1,0,FFFF,0,1
// - Underflow flag set on 0 to FFFF
// - Mode 10 transfers buffers at underflow
// - No transfer or overflow change after underflow
// - Buffer at or above period transfers at underflow
// - Then first in-range value transfers at underflow
// - Zero buffer transfers at period match
// - Then first in-range value transfers at match
package cpb_pkg;

    localparam int CPB_W = 16;
    localparam logic [1:0] CPB_MODE_TIMER = 2'h0;
    localparam logic [1:0] CPB_MODE_RSYNC = 2'h1;
    localparam logic [1:0] CPB_MODE_CMP_UDF = 2'h2;
    localparam logic [1:0] CPB_MODE_CMP_MATCH = 2'h3;
    localparam logic [15:0] CPB_CNT_RST = 16'h0000;
    localparam logic [15:0] CPB_CNT1_RST = 16'h0001;
    localparam logic [15:0] CPB_PERIOD_RST = 16'hffff;
    localparam logic [15:0] CPB_DUTY_RST = 16'hffff;

    // Per-channel forced transfer override
    typedef enum logic [1:0] {
        CPB_FORCE_NONE,
        CPB_FORCE_UDF,
        CPB_FORCE_MATCH
    } cpb_force_t;

    typedef struct packed {
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] c;
    } cpb_duty_t;

    typedef struct packed {
        logic a;
        logic b;
        logic c;
    } cpb_sel_t;

endpackage

// ==== cpb_chan.sv ====
// One duty channel: buffer transfer timing with out-of-range overrides
`timescale 1ns/1ps
module cpb_chan
    import cpb_pkg::*;
#(
    parameter int W = CPB_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic cmp_mode,
    input wire logic [1:0] mode,
    input wire logic buf_sel,
    input wire logic [W-1:0] buf_val,
    input wire logic [W-1:0] period,
    input wire logic match_ev,
    input wire logic udf_ev,
    output logic [W-1:0] duty
);

    logic [W-1:0] duty_q, duty_d;
    cpb_force_t force_q, force_d;
    logic xfer;

    always_comb begin
        force_d = force_q;
        duty_d = duty_q;
        xfer = 1'b0;
        if (!cmp_mode) begin
            force_d = CPB_FORCE_NONE;
            if (load) begin
                duty_d = load_val;
            end
        end else if (buf_sel) begin
            if (buf_val >= period) begin
                force_d = CPB_FORCE_UDF;
            end else if (buf_val == '0) begin
                force_d = CPB_FORCE_MATCH;
            end
            case (force_q)
                CPB_FORCE_UDF: xfer = udf_ev;
                CPB_FORCE_MATCH: xfer = match_ev;
                CPB_FORCE_NONE: begin
                    if (buf_val >= period) begin
                        xfer = udf_ev;
                    end else if (buf_val == '0) begin
                        xfer = match_ev;
                    end else if (mode == CPB_MODE_CMP_MATCH) begin
                        xfer = match_ev;
                    end else begin
                        xfer = udf_ev;
                    end
                end
                default: xfer = 1'b0;
            endcase
            if (xfer) begin
                duty_d = buf_val;
                // First in-range transfer ends the override
                if (buf_val != '0 && buf_val < period) begin
                    force_d = CPB_FORCE_NONE;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            duty_q <= CPB_DUTY_RST;
            force_q <= CPB_FORCE_NONE;
        end else begin
            duty_q <= duty_d;
            force_q <= force_d;
        end
    end

    assign duty = duty_q;

endmodule

// ==== cpb_top.sv ====
// Complementary PWM counters, flags and buffer transfer control
`timescale 1ns/1ps
module cpb_top
    import cpb_pkg::*;
#(
    parameter int W = CPB_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic counter0_run,
    input wire logic counter1_run,
    input wire logic [1:0] combined_mode,
    input wire logic period_wr,
    input wire logic [W-1:0] period_wdata,
    input wire logic duty_wr,
    input wire cpb_duty_t duty_wdata,
    input wire cpb_duty_t duty_buffer,
    input wire cpb_sel_t buffer_select,
    input wire logic period_match_clr,
    input wire logic underflow_clr,
    input wire logic overflow_clr,
    output logic [W-1:0] counter_zero,
    output logic [W-1:0] counter_one,
    output logic [W-1:0] period_compare,
    output cpb_duty_t duty_compare,
    output logic period_match_flag,
    output logic underflow_flag,
    output logic overflow_flag,
    output logic pwm_active
);

    // =====================================================
    // Counters
    // =====================================================
    logic [W-1:0] cnt0_q, cnt0_d, cnt1_q, cnt1_d, per_q, per_d;
    logic up0_q, up0_d, up1_q, up1_d;
    logic cmp_mode, running, match_ev, udf_ev, ovf_ev;

    assign cmp_mode = combined_mode[1];
    assign running = counter0_run && counter1_run;

    always_comb begin
        cnt0_d = cnt0_q;
        cnt1_d = cnt1_q;
        up0_d = up0_q;
        up1_d = up1_q;
        per_d = per_q;
        match_ev = 1'b0;
        udf_ev = 1'b0;
        ovf_ev = 1'b0;
        // Period held fixed once complementary counting runs
        if (period_wr && !(cmp_mode && running)) begin
            per_d = period_wdata;
        end
        if (cmp_mode && running) begin
            if (up0_q) begin
                cnt0_d = W'(cnt0_q + 1'b1);
                if (cnt0_q == per_q) begin
                    match_ev = 1'b1;
                    up0_d = 1'b0;
                end
            end else begin
                cnt0_d = W'(cnt0_q - 1'b1);
                if (cnt0_q == '0) begin
                    up0_d = 1'b1;
                end
            end
            if (up1_q) begin
                cnt1_d = W'(cnt1_q + 1'b1);
                if (cnt1_q == per_q) begin
                    up1_d = 1'b0;
                end
                if (cnt1_q == '1) begin
                    ovf_ev = 1'b0;
                end
            end else begin
                cnt1_d = W'(cnt1_q - 1'b1);
                if (cnt1_q == '0) begin
                    udf_ev = 1'b1;
                    up1_d = 1'b1;
                end
            end
        end else if (!cmp_mode) begin
            cnt0_d = CPB_CNT_RST;
            cnt1_d = CPB_CNT1_RST;
            up0_d = 1'b1;
            up1_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt0_q <= CPB_CNT_RST;
            cnt1_q <= CPB_CNT1_RST;
            up0_q <= 1'b1;
            up1_q <= 1'b0;
            per_q <= CPB_PERIOD_RST;
        end else begin
            cnt0_q <= cnt0_d;
            cnt1_q <= cnt1_d;
            up0_q <= up0_d;
            up1_q <= up1_d;
            per_q <= per_d;
        end
    end

    // =====================================================
    // Flags, set wins over clear
    // =====================================================
    logic imf_q, imf_d, udf_q, udf_d, ovf_q, ovf_d, act_q;

    always_comb begin
        imf_d = (imf_q && !period_match_clr) || match_ev;
        udf_d = (udf_q && !underflow_clr) || udf_ev;
        ovf_d = (ovf_q && !overflow_clr) || ovf_ev;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            imf_q <= 1'b0;
            udf_q <= 1'b0;
            ovf_q <= 1'b0;
            act_q <= 1'b0;
        end else begin
            imf_q <= imf_d;
            udf_q <= udf_d;
            ovf_q <= ovf_d;
            act_q <= cmp_mode && running;
        end
    end

    // =====================================================
    // Duty channels
    // =====================================================
    logic dload;
    assign dload = duty_wr && !(cmp_mode && running);

    cpb_chan #(.W(W)) u_a (
        .clk(clk), .rst(rst), .load(dload), .load_val(duty_wdata.a),
        .cmp_mode(cmp_mode), .mode(combined_mode), .buf_sel(buffer_select.a),
        .buf_val(duty_buffer.a), .period(per_q), .match_ev(match_ev),
        .udf_ev(udf_ev), .duty(duty_compare.a)
    );
    cpb_chan #(.W(W)) u_b (
        .clk(clk), .rst(rst), .load(dload), .load_val(duty_wdata.b),
        .cmp_mode(cmp_mode), .mode(combined_mode), .buf_sel(buffer_select.b),
        .buf_val(duty_buffer.b), .period(per_q), .match_ev(match_ev),
        .udf_ev(udf_ev), .duty(duty_compare.b)
    );
    cpb_chan #(.W(W)) u_c (
        .clk(clk), .rst(rst), .load(dload), .load_val(duty_wdata.c),
        .cmp_mode(cmp_mode), .mode(combined_mode), .buf_sel(buffer_select.c),
        .buf_val(duty_buffer.c), .period(per_q), .match_ev(match_ev),
        .udf_ev(udf_ev), .duty(duty_compare.c)
    );

    assign counter_zero = cnt0_q;
    assign counter_one = cnt1_q;
    assign period_compare = per_q;
    assign period_match_flag = imf_q;
    assign underflow_flag = udf_q;
    assign overflow_flag = ovf_q;
    assign pwm_active = act_q;

endmodule

// ==== cpb_stage.sv ====
// Behavioural power stage fed by the duty compare values
`timescale 1ns/1ps
module cpb_stage
    import cpb_pkg::*;
#(
    parameter bit POL_POS = 1'b1,
    parameter bit POL_NEG = 1'b1
) (
    input wire logic [15:0] counter_zero,
    input wire cpb_duty_t duty_compare,
    output logic [2:0] gate_hi,
    output logic [2:0] gate_lo
);
    logic [2:0] on;
    assign on = {counter_zero < duty_compare.a, counter_zero < duty_compare.b,
        counter_zero < duty_compare.c};
    assign gate_hi = POL_POS ? on : ~on;
    assign gate_lo = POL_NEG ? ~on : on;
    initial begin
        if (POL_POS != POL_NEG) begin
            $error("stage polarity settings differ");
        end
    end
endmodule

// ==== cpb_monitor.sv ====
// Concurrent checks on the controller ports
`timescale 1ns/1ps
module cpb_monitor
    import cpb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic counter0_run,
    input wire logic counter1_run,
    input wire logic [1:0] combined_mode,
    input wire logic period_wr,
    input wire logic [15:0] counter_zero,
    input wire logic [15:0] counter_one,
    input wire logic [15:0] period_compare,
    input wire cpb_duty_t duty_compare,
    input wire logic period_match_flag,
    input wire logic underflow_flag,
    input wire logic overflow_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic run;
    assign run = counter0_run && counter1_run && combined_mode[1];
    sequence top_s;
        run && counter_zero == period_compare + 16'h1;
    endsequence
    sequence bot_s;
        run && counter_one == 16'hffff;
    endsequence
    top_turn_a: assert property (top_s |=> counter_zero == period_compare ##1
        (!run || counter_zero == period_compare - 16'h1)) else $error("top turn wrong");
    match_set_a: assert property (run && counter_zero == period_compare - 16'h1 ##1
        run && counter_zero == period_compare |=> counter_zero == period_compare + 16'h1 &&
        period_match_flag)
        else $error("period match step wrong");
    match_rise_a: assert property ($rose(period_match_flag) |->
        counter_zero == period_compare + 16'h1) else $error("match flag set off top");
    top_hold_a: assert property (top_s |=>
        ($stable(duty_compare) && !$rose(period_match_flag))[*2]) else $error("change after top");
    udf_set_a: assert property (run && counter_one == 16'h1 ##1 run && counter_one == 16'h0
        |=> counter_one == 16'hffff && underflow_flag) else $error("underflow step wrong");
    udf_rise_a: assert property ($rose(underflow_flag) |-> counter_one == 16'hffff)
        else $error("underflow flag set off bottom");
    bottom_turn_a: assert property (bot_s |=> counter_one == 16'h0)
        else $error("bottom turn wrong");
    bottom_hold_a: assert property (bot_s |=>
        ($stable(duty_compare) && $stable(overflow_flag))[*2]) else $error("change after bottom");
    period_fixed_a: assert property (run && period_wr |=> $stable(period_compare))
        else $error("period changed while running");
endmodule
bind cpb_top cpb_monitor mon (.clk, .rst, .counter0_run, .counter1_run, .combined_mode,
    .period_wr, .counter_zero, .counter_one, .period_compare, .duty_compare,
    .period_match_flag, .underflow_flag, .overflow_flag);

// ==== testbench.sv ====
// Self-checking bench for the complementary PWM controller
`timescale 1ns/1ps
module testbench
    import cpb_pkg::*;
;
    localparam logic [15:0] P = 16'h0014;
    logic clk, rst = 1'b1, counter0_run = 1'b0, counter1_run = 1'b0, period_wr = 1'b0;
    logic duty_wr = 1'b0, period_match_clr = 1'b0, underflow_clr = 1'b0, overflow_clr = 1'b0;
    logic period_match_flag, underflow_flag, overflow_flag, pwm_active;
    logic [1:0] combined_mode = 2'h0;
    logic [15:0] period_wdata = 16'h0, counter_zero, counter_one, period_compare;
    cpb_duty_t duty_wdata = '0, duty_buffer = '0, duty_compare;
    cpb_sel_t buffer_select = '0;
    logic [2:0] gate_hi, gate_lo;
    int errors = 0, num_checks = 0;
    cpb_top uut (.clk, .rst, .counter0_run, .counter1_run, .combined_mode, .period_wr,
        .period_wdata, .duty_wr, .duty_wdata, .duty_buffer, .buffer_select, .period_match_clr,
        .underflow_clr, .overflow_clr, .counter_zero, .counter_one, .period_compare,
        .duty_compare, .period_match_flag, .underflow_flag, .overflow_flag, .pwm_active);
    cpb_stage stage (.counter_zero, .duty_compare, .gate_hi, .gate_lo);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ====================
    // Access tasks
    task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic set_mode(input logic [1:0] m);
        counter0_run <= 1'b0;
        counter1_run <= 1'b0;
        @(posedge clk) combined_mode <= CPB_MODE_TIMER;
        @(posedge clk) combined_mode <= m;
        @(posedge clk);
    endtask
    task automatic ld(input cpb_duty_t v);
        buffer_select <= '0;
        @(posedge clk) duty_buffer <= v;
        @(posedge clk) buffer_select <= '1;
    endtask
    task automatic start(input cpb_duty_t v);
        period_wr <= 1'b1;
        period_wdata <= P;
        @(posedge clk) period_wr <= 1'b0;
        ld(v);
        @(posedge clk) counter0_run <= 1'b1;
        counter1_run <= 1'b1;
    endtask
    task automatic ev(input bit u, input cpb_duty_t exp);
        int n = 0;
        period_match_clr <= 1'b1;
        underflow_clr <= 1'b1;
        @(posedge clk) period_match_clr <= 1'b0;
        underflow_clr <= 1'b0;
        do begin
            @(posedge clk) #1 n++;
        end while (!(u ? underflow_flag : period_match_flag) && n < 100);
        chk(u ? "underflow flag" : "match flag", 1'b1, u ? underflow_flag : period_match_flag);
        chk("counter", u ? 16'hffff : P + 16'h1, u ? counter_one : counter_zero);
        chk("duty", exp, duty_compare);
        chk("overflow flag", 1'b0, overflow_flag);
        chk("active", 1'b1, pwm_active);
        @(posedge clk);
    endtask
    // ====================
    // Tests
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        set_mode(CPB_MODE_RSYNC);
        duty_wr <= 1'b1;
        duty_wdata <= '{16'h2, 16'h3, 16'h4};
        counter0_run <= 1'b1;
        counter1_run <= 1'b1;
        @(posedge clk) duty_wr <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk("direct duty", {16'h2, 16'h3, 16'h4}, duty_compare);
        chk("idle counter", 16'h0, counter_zero);
        chk("idle counter one", 16'h1, counter_one);
        chk("inactive", 1'b0, pwm_active);
        chk("gates", {45'h0, ~gate_hi}, gate_lo);
        $display("test reset sync done");
        set_mode(CPB_MODE_CMP_MATCH);
        start('{16'h5, 16'h6, 16'h7});
        ev(1'b0, '{16'h5, 16'h6, 16'h7});
        period_wr <= 1'b1;
        period_wdata <= 16'h0030;
        duty_wr <= 1'b1;
        @(posedge clk) period_wr <= 1'b0;
        duty_wr <= 1'b0;
        ld('{16'h1, 16'h2, 16'h3});
        ev(1'b1, '{16'h5, 16'h6, 16'h7});
        ev(1'b0, '{16'h1, 16'h2, 16'h3});
        chk("period", P, period_compare);
        $display("test match timing done");
        set_mode(CPB_MODE_CMP_UDF);
        start('{16'h8, 16'h9, 16'ha});
        ev(1'b1, '{16'h8, 16'h9, 16'ha});
        ld('{16'hc, 16'hd, 16'he});
        ev(1'b0, '{16'h8, 16'h9, 16'ha});
        ev(1'b1, '{16'hc, 16'hd, 16'he});
        $display("test underflow timing done");
        set_mode(CPB_MODE_CMP_MATCH);
        start('{P, 16'h0, 16'h9});
        ev(1'b1, '{P, 16'hd, 16'he});
        ev(1'b0, '{P, 16'h0, 16'h9});
        ld('{16'h4, 16'h3, 16'h9});
        ev(1'b1, '{16'h4, 16'h0, 16'h9});
        ev(1'b0, '{16'h4, 16'h3, 16'h9});
        ld('{16'hb, 16'hc, 16'hd});
        ev(1'b1, '{16'h4, 16'h3, 16'h9});
        ev(1'b0, '{16'hb, 16'hc, 16'hd});
        $display("test range override done");
        close_out;
    end
    initial begin
        #40000;
        errors++;
        close_out;
    end
endmodule
